// ===== core/usb_host_ctl_map.svh
// register map, field positions and timing constants of the bus control block
//
// Behaviour
// - host-mode power-on command drives the external power enable output active.
// - power enable active level is software selectable, high or low.
// - on power fault apply chosen action: none, tri-state, drive low or high.
// - software switch enables fault detection; when off no fault is recognised.
// - requested IN transaction is scheduled on the chosen endpoint for the link.
// - a pending IN request can be withdrawn before the link takes it.
// - status-phase IN request exists for endpoint zero only.
// - received endpoint-zero status packet raises an interrupt event.
// - host-mode bus reset is driven while set; software holds it at least 20 ms.
// - device-mode resume driven while set; software clears between 10 and 15 ms.
// - host-mode resume driven while set, finished on clear; held at least 20 ms.
// - host mode reports attached speed as low, full, high or undefined.
// - host-mode suspend command stops bus traffic, suspending the bus.
// - control event enable mask has separate set and clear per bit.
// - separate endpoint enable mask covers host and device events per endpoint.
// - reading control status returns pending events and clears them all.
// - reading endpoint status returns host/device groups and clears them all.
// - host flags vbus error, connect, disconnect, babble, fault; always sof, resume.
// - device flags reset, suspend, session end; otg flags session, cable mode.
`ifndef USB_HOST_CTL_MAP_SVH
`define USB_HOST_CTL_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_IN_REQ 8'h08
`define REG_IN_CLR 8'h0C
`define REG_STS_REQ 8'h10
`define REG_CIEN_SET 8'h14
`define REG_CIEN_CLR 8'h18
`define REG_EIEN_SET 8'h1C
`define REG_EIEN_CLR 8'h20
`define REG_CISTAT 8'h24
`define REG_EISTAT 8'h28

// ****************************************
// control register fields
// ****************************************
`define CTRL_MODE_LO 0
`define CTRL_PWR_EN 2
`define CTRL_PWR_HIGH 3
`define CTRL_FLT_ACT_LO 4
`define CTRL_FLT_DET 6
`define CTRL_FLT_HIGH 7
`define CTRL_BUS_RST 8
`define CTRL_RESUME 9
`define CTRL_SUSPEND 10
`define CTRL_RESET_VAL 32'h0000_0008

// ****************************************
// timing
// ****************************************
`define CLK_KHZ 125000
`define T_RESET_MIN_MS 20
`define T_HRES_MIN_MS 20
`define T_DRES_MIN_MS 10
`define T_DRES_MAX_MS 15
`define RESET_MIN_CYC (`T_RESET_MIN_MS * `CLK_KHZ)
`define HRES_MIN_CYC (`T_HRES_MIN_MS * `CLK_KHZ)
`define DRES_MIN_CYC (`T_DRES_MIN_MS * `CLK_KHZ)
`define DRES_MAX_CYC (`T_DRES_MAX_MS * `CLK_KHZ)

`endif

// ===== core/usb_host_ctl_pkg.sv
// types shared by the bus control block
package usb_host_ctl_pkg;

    typedef enum logic [1:0] {
        MODE_HOST = 2'h0,
        MODE_DEVICE = 2'h1,
        MODE_OTG = 2'h2
    } mode_e;

    typedef enum logic [1:0] {
        SPEED_UNDEF = 2'h0,
        SPEED_LOW = 2'h1,
        SPEED_FULL = 2'h2,
        SPEED_HIGH = 2'h3
    } speed_e;

    typedef enum logic [1:0] {
        FLT_NONE = 2'h0,
        FLT_TRI = 2'h1,
        FLT_LOW = 2'h2,
        FLT_HIGH = 2'h3
    } flt_act_e;

    // control event flags, bit 11 first
    typedef struct packed {
        logic power_fault_flag;
        logic cable_mode_done_flag;
        logic suspend;
        logic resume;
        logic bus_reset;
        logic babble_flag;
        logic sof;
        logic connect;
        logic disconnect;
        logic session_end;
        logic session;
        logic vbus_error_flag;
    } ctl_ev_s;

endpackage

// ===== core/usb_host_ctl.sv
// bus power, in-request, signalling and event flag control of the usb controller
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "usb_host_ctl_map.svh"

module usb_host_ctl
    import usb_host_ctl_pkg::*;
#(
    parameter int NUM_EP = 16,
    parameter logic [23:0] RESET_MIN_CYC = 24'(`RESET_MIN_CYC),
    parameter logic [23:0] HRES_MIN_CYC = 24'(`HRES_MIN_CYC),
    parameter logic [23:0] DRES_MIN_CYC = 24'(`DRES_MIN_CYC),
    parameter logic [23:0] DRES_MAX_CYC = 24'(`DRES_MAX_CYC)
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // link engine side
    input wire ctl_ev_s link_ev_i,
    input wire speed_e link_speed_i,
    input wire logic [NUM_EP-1:0] ep_host_ev_i,
    input wire logic [NUM_EP-1:0] ep_dev_ev_i,
    input wire logic [NUM_EP-1:0] in_taken_i,
    input wire logic status_rcvd_i,
    output logic [NUM_EP-1:0] in_req_o,
    output logic status_req_o,
    output logic bus_reset_o,
    output logic resume_o,
    output logic suspend_o,
    // power pins
    input wire logic power_fault_in_i,
    output logic ext_power_enable_out_o,
    output logic ext_power_enable_out_oe_o,
    // interrupt
    output logic irq_o
);

    // ****************************************
    // declarations
    // ****************************************
    localparam int NEV = $bits(ctl_ev_s);

    logic [31:0] ctrl_r;
    logic [NEV-1:0] cien_r;
    logic [2*NUM_EP-1:0] eien_r;
    logic [NEV-1:0] cflag_r;
    logic [2*NUM_EP-1:0] eflag_r;
    logic [NUM_EP-1:0] in_req_r;
    logic status_req_r;
    logic [31:0] rdata_r;
    logic flt_s1_r;
    logic flt_s2_r;
    logic flt_s3_r;
    logic flt_q_r;
    logic flt_det_d_r;
    logic flt_latched_r;
    logic [23:0] hold_cnt_r;
    logic [31:0] stat_w;
    logic [31:0] rd_mux;
    mode_e mode;
    flt_act_e flt_act;
    logic is_host;
    logic is_dev;
    logic is_otg;
    logic flt_det;
    logic flt_rise;
    logic res_end;
    logic hold_min_ok;
    logic hold_over;
    ctl_ev_s ev_gated;
    logic [NEV-1:0] cset;
    logic [2*NUM_EP-1:0] eset;
    logic [NUM_EP-1:0] ep0_bit;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign mode = mode_e'(ctrl_r[`CTRL_MODE_LO +: 2]);
    assign flt_act = flt_act_e'(ctrl_r[`CTRL_FLT_ACT_LO +: 2]);
    assign is_host = (mode == MODE_HOST);
    assign is_dev = (mode == MODE_DEVICE);
    assign is_otg = (mode == MODE_OTG);
    assign ep0_bit = {{(NUM_EP-1){1'b0}}, 1'b1};

    // ****************************************
    // control register
    // ****************************************
    // host resume end also ends the suspended state
    assign res_end = is_host && ctrl_r[`CTRL_RESUME] && wr_i && hit(addr_i, `REG_CTRL)
        && !wdata_i[`CTRL_RESUME];

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_r <= `CTRL_RESET_VAL;
        end
        else if (wr_i && hit(addr_i, `REG_CTRL))
        begin
            ctrl_r <= {21'h00_0000, wdata_i[10:0]};
            if (res_end)
            begin
                ctrl_r[`CTRL_SUSPEND] <= 1'b0;
            end
        end
    end

    // ****************************************
    // power fault pin: three stage sync
    // ****************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            flt_s1_r <= 1'b0;
            flt_s2_r <= 1'b0;
            flt_s3_r <= 1'b0;
            flt_q_r <= 1'b0;
        end
        else
        begin
            flt_s1_r <= power_fault_in_i;
            flt_s2_r <= flt_s1_r;
            flt_s3_r <= flt_s2_r;
            if (flt_s2_r == flt_s3_r)
            begin
                flt_q_r <= flt_s3_r;
            end
        end
    end

    // detection gated off entirely when disabled, so a floating pin is harmless
    assign flt_det = ctrl_r[`CTRL_FLT_DET] && is_host
        && (flt_q_r == ctrl_r[`CTRL_FLT_HIGH]);
    assign flt_rise = flt_det && !flt_det_d_r;

    // fault action holds until software drops the power command or fault detection
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            flt_det_d_r <= 1'b0;
            flt_latched_r <= 1'b0;
        end
        else
        begin
            flt_det_d_r <= flt_det;
            if (flt_rise)
            begin
                flt_latched_r <= 1'b1;
            end
            else if (!ctrl_r[`CTRL_PWR_EN] || !ctrl_r[`CTRL_FLT_DET])
            begin
                flt_latched_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // power enable pin
    // ****************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            ext_power_enable_out_o <= 1'b0;
            ext_power_enable_out_oe_o <= 1'b0;
        end
        else
        begin
            ext_power_enable_out_oe_o <= 1'b1;
            // active level selectable, inactive is its inverse
            ext_power_enable_out_o <= (is_host && ctrl_r[`CTRL_PWR_EN])
                ? ctrl_r[`CTRL_PWR_HIGH] : !ctrl_r[`CTRL_PWR_HIGH];
            if (flt_latched_r)
            begin
                case (flt_act)
                    FLT_TRI: ext_power_enable_out_oe_o <= 1'b0;
                    FLT_LOW: ext_power_enable_out_o <= 1'b0;
                    FLT_HIGH: ext_power_enable_out_o <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // in requests and status request
    // ****************************************
    // requests accepted only in host mode; direction is software's duty
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            in_req_r <= '0;
        end
        else
        begin
            in_req_r <= in_req_r & ~in_taken_i;
            if (is_host && wr_i && hit(addr_i, `REG_IN_REQ))
            begin
                in_req_r <= (in_req_r & ~in_taken_i) | wdata_i[NUM_EP-1:0];
            end
            else if (is_host && wr_i && hit(addr_i, `REG_IN_CLR))
            begin
                in_req_r <= in_req_r & ~in_taken_i & ~wdata_i[NUM_EP-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            status_req_r <= 1'b0;
        end
        else if (is_host && wr_i && hit(addr_i, `REG_STS_REQ) && wdata_i[0])
        begin
            status_req_r <= 1'b1;
        end
        else if (in_taken_i[0])
        begin
            status_req_r <= 1'b0;
        end
    end

    assign in_req_o = in_req_r;
    assign status_req_o = status_req_r;

    // ****************************************
    // bus signalling
    // ****************************************
    assign bus_reset_o = is_host && ctrl_r[`CTRL_BUS_RST];
    assign resume_o = ctrl_r[`CTRL_RESUME] && (is_host || is_dev);
    assign suspend_o = is_host && ctrl_r[`CTRL_SUSPEND] && !ctrl_r[`CTRL_RESUME];

    // hold timer shows software when the bus reset or resume may end
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            hold_cnt_r <= '0;
        end
        else if (!(bus_reset_o || resume_o))
        begin
            hold_cnt_r <= '0;
        end
        else if (hold_cnt_r != 24'hFF_FFFF)
        begin
            hold_cnt_r <= hold_cnt_r + 24'h00_0001;
        end
    end

    assign hold_min_ok = bus_reset_o ? (hold_cnt_r >= RESET_MIN_CYC)
        : is_host ? (hold_cnt_r >= HRES_MIN_CYC)
        : (hold_cnt_r >= DRES_MIN_CYC);
    assign hold_over = is_dev && resume_o && (hold_cnt_r > DRES_MAX_CYC);

    // ****************************************
    // event flags
    // ****************************************
    always_comb
    begin
        ev_gated = link_ev_i;
        // host only sources
        ev_gated.vbus_error_flag = link_ev_i.vbus_error_flag && is_host;
        ev_gated.connect = link_ev_i.connect && is_host;
        ev_gated.disconnect = link_ev_i.disconnect && is_host;
        ev_gated.babble_flag = link_ev_i.babble_flag && is_host;
        ev_gated.power_fault_flag = flt_rise;
        // device and otg only sources
        ev_gated.bus_reset = link_ev_i.bus_reset && is_dev;
        ev_gated.suspend = link_ev_i.suspend && is_dev;
        ev_gated.session_end = link_ev_i.session_end && is_dev;
        ev_gated.session = link_ev_i.session && is_otg;
        ev_gated.cable_mode_done_flag = link_ev_i.cable_mode_done_flag && is_otg;
    end

    assign cset = ev_gated;
    // ep0 status packet reported as an endpoint zero host event
    assign eset = {ep_dev_ev_i, ep_host_ev_i | (status_rcvd_i ? ep0_bit : '0)};

    // a new event in the read cycle survives the clear-on-read
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            cflag_r <= '0;
            eflag_r <= '0;
        end
        else
        begin
            cflag_r <= ((rd_i && hit(addr_i, `REG_CISTAT)) ? '0 : cflag_r) | cset;
            eflag_r <= ((rd_i && hit(addr_i, `REG_EISTAT)) ? '0 : eflag_r) | eset;
        end
    end

    // ****************************************
    // enable masks
    // ****************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            cien_r <= '0;
            eien_r <= '0;
        end
        else if (wr_i)
        begin
            if (hit(addr_i, `REG_CIEN_SET))
            begin
                cien_r <= cien_r | wdata_i[NEV-1:0];
            end
            if (hit(addr_i, `REG_CIEN_CLR))
            begin
                cien_r <= cien_r & ~wdata_i[NEV-1:0];
            end
            if (hit(addr_i, `REG_EIEN_SET))
            begin
                eien_r <= eien_r | wdata_i[2*NUM_EP-1:0];
            end
            if (hit(addr_i, `REG_EIEN_CLR))
            begin
                eien_r <= eien_r & ~wdata_i[2*NUM_EP-1:0];
            end
        end
    end

    assign irq_o = |(cflag_r & cien_r) || |(eflag_r & eien_r);

    // ****************************************
    // read port
    // ****************************************
    always_comb
    begin
        stat_w = '0;
        stat_w[1:0] = is_host ? link_speed_i : SPEED_UNDEF;
        stat_w[2] = flt_latched_r;
        stat_w[3] = flt_q_r;
        stat_w[4] = hold_min_ok;
        stat_w[5] = hold_over;
        stat_w[6] = suspend_o;
    end

    always_comb
    begin
        rd_mux = '0;
        case (addr_i)
            `REG_CTRL: rd_mux = ctrl_r;
            `REG_STAT: rd_mux = stat_w;
            `REG_IN_REQ: rd_mux[NUM_EP-1:0] = in_req_r;
            `REG_STS_REQ: rd_mux[0] = status_req_r;
            `REG_CIEN_SET: rd_mux[NEV-1:0] = cien_r;
            `REG_EIEN_SET: rd_mux[2*NUM_EP-1:0] = eien_r;
            `REG_CISTAT: rd_mux[NEV-1:0] = cflag_r;
            `REG_EISTAT: rd_mux[2*NUM_EP-1:0] = eflag_r;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            rdata_r <= '0;
        end
        else
        begin
            rdata_r <= rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_r;

endmodule // usb_host_ctl

// ===== sim/usb_host_ctl_monitor.sv
// concurrent checks on the ports of the bus control block
`timescale 1ns/1ps
`include "usb_host_ctl_map.svh"

module usb_host_ctl_monitor
    import usb_host_ctl_pkg::*;
#(
    parameter int NUM_EP = 16
)
(
    // clock and reset
    input logic clk_sys_i,
    input logic rst_b_i,
    // register port
    input logic [7:0] addr_i,
    input logic [31:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    input logic [31:0] rdata_o,
    // link side
    input ctl_ev_s link_ev_i,
    input logic [NUM_EP-1:0] in_req_o,
    input logic status_req_o,
    input logic bus_reset_o,
    input logic resume_o,
    input logic suspend_o,
    // pins
    input logic power_fault_in_i,
    input logic ext_power_enable_out_o,
    input logic ext_power_enable_out_oe_o,
    input logic irq_o
);
    logic [10:0] ctl_r;
    logic det_q_r;
    logic [3:0] flt_cnt_r;
    logic host;
    logic pin_exp;
    logic [NUM_EP-1:0] wep;
    assign host = ctl_r[1:0] == MODE_HOST;
    assign pin_exp = host && ctl_r[2] ? ctl_r[3] : !ctl_r[3];
    assign wep = wdata_i[NUM_EP-1:0];
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            ctl_r <= 11'h008;
        else if (wr_i && addr_i == `REG_CTRL)
            ctl_r <= wdata_i[10:0];
    end
    always_ff @(posedge clk_sys_i)
    begin
        det_q_r <= ctl_r[6];
        if (!rst_b_i || !(host && ctl_r[2] && ctl_r[6] && power_fault_in_i == ctl_r[7]))
            flt_cnt_r <= 4'h0;
        else if (flt_cnt_r != 4'hf)
            flt_cnt_r <= flt_cnt_r + 4'h1;
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    sequence cist_rd;
        rd_i && addr_i == `REG_CISTAT && link_ev_i == '0 && !ctl_r[6];
    endsequence

    pwr_level_a: assert property (
        !ctl_r[6] && !det_q_r |=> ext_power_enable_out_oe_o &&
        ext_power_enable_out_o == $past(pin_exp)) else $error("pin level");
    fault_act_a: assert property (
        flt_cnt_r == 4'hc |-> (ext_power_enable_out_oe_o == (ctl_r[5:4] != FLT_TRI)) &&
        (ctl_r[5:4] == FLT_TRI || ext_power_enable_out_o ==
        (ctl_r[5:4] == FLT_NONE ? ctl_r[3] : ctl_r[5:4] == FLT_HIGH)))
        else $error("fault action");
    bus_reset_a: assert property (host |-> bus_reset_o == ctl_r[8])
        else $error("bus reset");
    resume_lvl_a: assert property (
        ctl_r[1:0] != MODE_OTG |-> resume_o == ctl_r[9]) else $error("resume");
    suspend_lvl_a: assert property (
        host |-> suspend_o == (ctl_r[10] && !ctl_r[9])) else $error("suspend");
    irq_hold_a: assert property (irq_o && !rd_i && !wr_i |=> irq_o)
        else $error("irq dropped");
    rd_clear_a: assert property (cist_rd ##1 cist_rd |=> rdata_o == 32'h0)
        else $error("flags kept");
    in_set_a: assert property (
        wr_i && addr_i == `REG_IN_REQ && host |=> (in_req_o & $past(wep)) == $past(wep))
        else $error("in not set");
    in_clr_a: assert property (
        wr_i && addr_i == `REG_IN_CLR && host |=> (in_req_o & $past(wep)) == '0)
        else $error("in not cleared");
    status_req_a: assert property (
        wr_i && addr_i == `REG_STS_REQ && host && wdata_i[0] |=> status_req_o)
        else $error("no status req");

    cover property (flt_cnt_r == 4'hc && ctl_r[5:4] == FLT_TRI);
    cover property ($rose(irq_o));
    cover property (cist_rd ##1 cist_rd);
endmodule // usb_host_ctl_monitor

bind usb_host_ctl usb_host_ctl_monitor #(.NUM_EP(NUM_EP)) mon (.clk_sys_i, .rst_b_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .link_ev_i, .in_req_o, .status_req_o, .bus_reset_o,
    .resume_o, .suspend_o, .power_fault_in_i, .ext_power_enable_out_o,
    .ext_power_enable_out_oe_o, .irq_o);

// ===== sim/usb_link_model.sv
// far-side model: attached device taking scheduled in transactions
`timescale 1ns/1ps

module usb_link_model #(
    parameter int NUM_EP = 4
)
(
    // clock and reset
    input logic clk_sys_i,
    input logic rst_b_i,
    // pacing
    input logic stall_i,
    // requests
    input logic [NUM_EP-1:0] in_req_i,
    input logic status_req_i,
    // answers
    output logic [NUM_EP-1:0] in_taken_o,
    output logic [NUM_EP-1:0] ep_data_o,
    output logic status_rcvd_o
);
    // one take at a time, lowest endpoint first
    logic [2:0] gap_r;
    logic sts_r;
    logic [NUM_EP-1:0] pick;
    assign pick = in_req_i & (~in_req_i + NUM_EP'(1));
    // a taken request stays visible one more cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            gap_r <= 3'h0;
            sts_r <= 1'b0;
            in_taken_o <= '0;
            ep_data_o <= '0;
            status_rcvd_o <= 1'b0;
        end
        else
        begin
            in_taken_o <= '0;
            sts_r <= 1'b0;
            status_rcvd_o <= sts_r;
            ep_data_o <= sts_r ? '0 : in_taken_o;
            if (gap_r != 3'h0)
                gap_r <= gap_r - 3'h1;
            else if (!stall_i && status_req_i)
            begin
                in_taken_o <= NUM_EP'(1);
                sts_r <= 1'b1;
                gap_r <= 3'h3;
            end
            else if (!stall_i && in_req_i != '0)
            begin
                in_taken_o <= pick;
                gap_r <= 3'h3;
            end
        end
    end
endmodule // usb_link_model

// ===== sim/tb_usb_host_ctl.sv
// self-checking bench of the bus control block
`timescale 1ns/1ps
`include "usb_host_ctl_map.svh"

module tb_usb_host_ctl;
    import usb_host_ctl_pkg::*;
    localparam int NE = 4;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    ctl_ev_s link_ev_i = '0;
    speed_e link_speed_i = SPEED_UNDEF;
    logic [NE-1:0] ep_dev_ev_i = '0;
    logic power_fault_in_i = 1'b0;
    logic stall = 1'b1;
    logic [31:0] rdata_o;
    logic [NE-1:0] ep_host_ev_i, in_taken_i, in_req_o;
    logic status_rcvd_i, status_req_o, bus_reset_o, resume_o, suspend_o, irq_o;
    logic ext_power_enable_out_o, ext_power_enable_out_oe_o;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [31:0] rnd_s = 32'h2a9f_060c;
    logic [31:0] d1, d2, r, m, v, cm, em;
    logic [11:0] ev;
    logic [1:0] md;

    usb_host_ctl #(.NUM_EP(NE), .RESET_MIN_CYC(24'h14), .HRES_MIN_CYC(24'h14),
        .DRES_MIN_CYC(24'h0a), .DRES_MAX_CYC(24'h0f)) DUT (.clk_sys_i, .rst_b_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .link_ev_i, .link_speed_i, .ep_host_ev_i,
        .ep_dev_ev_i, .in_taken_i, .status_rcvd_i, .in_req_o, .status_req_o, .bus_reset_o,
        .resume_o, .suspend_o, .power_fault_in_i, .ext_power_enable_out_o,
        .ext_power_enable_out_oe_o, .irq_o);
    usb_link_model #(.NUM_EP(NE)) link (.clk_sys_i, .rst_b_i, .stall_i(stall),
        .in_req_i(in_req_o), .status_req_i(status_req_o), .in_taken_o(in_taken_i),
        .ep_data_o(ep_host_ev_i), .status_rcvd_o(status_rcvd_i));

    function automatic logic [31:0] rnd();
        rnd_s = rnd_s ^ (rnd_s << 13);
        rnd_s = rnd_s ^ (rnd_s >> 17);
        rnd_s = rnd_s ^ (rnd_s << 5);
        return rnd_s;
    endfunction
    function automatic logic [11:0] ev_exp(logic [1:0] mode, logic [11:0] e);
        case (mode)
            MODE_HOST: return e & 12'h179;
            MODE_DEVICE: return e & 12'h3a4;
            default: return e & 12'h522;
        endcase
    endfunction
    function automatic logic pin_exp(logic lvl, logic on);
        return on ? lvl : !lvl;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    // back to back; d2 is after the clear
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 d1 = rdata_o;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 d2 = rdata_o;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        repeat (6000) @(posedge clk_sys_i);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd(`REG_CTRL);
        chk("ctrl reset", `CTRL_RESET_VAL, d1);
        chk("pin idle", 0, ext_power_enable_out_o);
        rd(8'hfc);
        chk("unmapped", 0, d1);
        $display("test reset done");
        for (int l = 0; l < 2; l++)
        begin
            wr(`REG_CTRL, 32'h4 | (32'(l) << 3));
            tick(2);
            chk("pwr on", pin_exp(l[0], 1'b1), ext_power_enable_out_o);
            wr(`REG_CTRL, 32'h5 | (32'(l) << 3));
            tick(2);
            chk("pwr dev", pin_exp(l[0], 1'b0), ext_power_enable_out_o);
        end
        $display("test power done");
        wr(`REG_CTRL, 32'h8c);
        power_fault_in_i <= 1'b1;
        tick(20);
        chk("no det pin", 1, ext_power_enable_out_o);
        rd(`REG_CISTAT);
        chk("no det flag", 0, d1[11]);
        power_fault_in_i <= 1'b0;
        for (int a = 0; a < 4; a++)
        begin
            wr(`REG_CTRL, 32'hcc | (32'(a) << 4));
            tick(8);
            power_fault_in_i <= 1'b1;
            tick(14);
            chk("fault oe", a != 1, ext_power_enable_out_oe_o);
            if (a != 1) chk("fault pin", a != 2, ext_power_enable_out_o);
            rd(`REG_CISTAT);
            chk("fault flag", 1, d1[11]);
            power_fault_in_i <= 1'b0;
            wr(`REG_CTRL, 32'h8c); // detection off while the pin idles
        end
        $display("test fault done");
        for (int i = 0; i < 8; i++)
        begin
            link_speed_i <= speed_e'(i[1:0]);
            wr(`REG_CTRL, 32'(i[2]));
            rd(`REG_STAT);
            chk("speed", i[2] ? 2'h0 : i[1:0], d1[1:0]);
        end
        $display("test speed done");
        wr(`REG_CTRL, 32'h0);
        rd(`REG_EISTAT);
        r = (rnd() % 15) + 1;
        wr(`REG_IN_REQ, r);
        rd(`REG_IN_REQ);
        chk("in pend", r, d1);
        m = rnd() & 32'hf;
        wr(`REG_IN_CLR, m);
        wr(`REG_CTRL, 32'h1);
        wr(`REG_IN_REQ, 32'hf);
        wr(`REG_STS_REQ, 32'h1);
        tick(2);
        chk("sts dev", 0, status_req_o);
        wr(`REG_CTRL, 32'h0);
        rd(`REG_IN_REQ);
        chk("in wdraw", r & ~m, d1);
        stall <= 1'b0;
        tick(40);
        rd(`REG_EISTAT);
        chk("in data", r & ~m, d1);
        chk("ep clr", 0, d2);
        wr(`REG_STS_REQ, 32'h1);
        tick(20);
        rd(`REG_EISTAT);
        chk("sts rcvd", 1, d1);
        $display("test in done");
        cm = '0;
        em = '0;
        for (int i = 0; i < 24; i++)
        begin
            v = rnd() % 3;
            md = v[1:0];
            wr(`REG_CTRL, 32'(md));
            v = rnd() & 32'hfff;
            wr(i[0] ? `REG_CIEN_CLR : `REG_CIEN_SET, v);
            cm = i[0] ? cm & ~v : cm | v;
            v = rnd() & 32'hff;
            wr(i[1] ? `REG_EIEN_CLR : `REG_EIEN_SET, v);
            em = i[1] ? em & ~v : em | v;
            rd(`REG_CISTAT);
            rd(`REG_EISTAT);
            v = rnd();
            ev = v[11:0];
            link_ev_i <= ev;
            ep_dev_ev_i <= v[15:12];
            @(posedge clk_sys_i);
            link_ev_i <= '0;
            ep_dev_ev_i <= '0;
            tick(3);
            chk("irq", |(ev_exp(md, ev) & cm[11:0]) || |({v[15:12], 4'h0} & em[7:0]),
                irq_o);
            rd(`REG_CISTAT);
            chk("ctl ev", ev_exp(md, ev), d1);
            chk("ctl clr", 0, d2);
            rd(`REG_EISTAT);
            chk("ep ev", {v[15:12], 4'h0}, d1);
            rd(`REG_CIEN_SET);
            chk("ctl mask", cm, d1);
        end
        $display("test events done");
        wr(`REG_CTRL, 32'h100);
        rd(`REG_STAT);
        chk("rst on", 1, bus_reset_o);
        chk("rst short", 0, d1[4]);
        tick(20);
        rd(`REG_STAT);
        chk("rst held", 1, d1[4]);
        wr(`REG_CTRL, 32'h400);
        tick(1);
        chk("susp on", 1, suspend_o);
        wr(`REG_CTRL, 32'h600);
        tick(1);
        chk("hres on", 1, resume_o);
        tick(22);
        wr(`REG_CTRL, 32'h0);
        tick(1);
        chk("hres end", 0, {resume_o, suspend_o, bus_reset_o});
        wr(`REG_CTRL, 32'h201);
        tick(11);
        rd(`REG_STAT);
        chk("dres min", 1, d1[4]);
        chk("dres max", 0, d1[5]);
        tick(6);
        rd(`REG_STAT);
        chk("dres over", 1, d1[5]);
        $display("test signalling done");
        stop_test();
    end
endmodule // tb_usb_host_ctl
